// ==== jtag_tap_defs.svh ====
// Constants for the boundary scan test access port controller
// What this block does
// - Sixteen states, stepped by mode select on rising edge
// - Five high mode select edges force reset state
// - Power-up reset needs no test clock
// - Reset state: test logic off, identify instruction
// - Idle holds while low, high goes select-data
// - Select-data: low captures, high selects instruction
// - Capture-data loads pins for external or sample
// - Capture-data: high exit1, low shift
// - Shift-data shifts selected register toward output
// - Exit1-data: high update, low pause
// - Pause-data holds register, high goes exit2
// - Exit2-data: high update, low back to shift
// - Update-data latches scan outputs on falling edge
// - Select-instruction: low capture, high reset state
// - Capture-instruction loads fixed pattern one-zero-zero
// - Capture-instruction: high exit1, low shift
// - Shift-instruction shifts instruction register toward output
// - Exit1-instruction: high update, low pause
// - Pause-instruction holds, high goes exit2
// - Exit2-instruction: high update, low shift
// - Update-instruction latches instruction on falling edge
`ifndef JTAG_TAP_DEFS_SVH
`define JTAG_TAP_DEFS_SVH
`define TAP_IR_WIDTH        3
`define TAP_IR_CAPTURE      3'h4
`define TAP_IR_EXTEST       3'h0
`define TAP_IR_SAMPLE       3'h1
`define TAP_IR_IDCODE       3'h2
`define TAP_IR_BYPASS       3'h7
// Identification value is arbitrary
`define TAP_IDCODE_VALUE    32'h0000_0a01
`define TAP_ID_WIDTH        32
`define TAP_BSR_LEN         16
`endif

// ==== jtag_tap_fsm.sv ====
// Sixteen-state test access port sequencer
module jtag_tap_fsm
	import jtag_tap_pkg::*;
(
	input  wire logic       tck_in,
	input  wire logic       tap_rst_n_in,
	input  wire logic       tms_in,
	output tap_state_t      state_out
);
	tap_state_t state_ff;
	tap_state_t nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			TEST_LOGIC_RESET: nxt_state = tms_in ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
			RUN_TEST_IDLE:    nxt_state = tms_in ? SELECT_DR_SCAN : RUN_TEST_IDLE;
			SELECT_DR_SCAN:   nxt_state = tms_in ? SELECT_IR_SCAN : CAPTURE_DR;
			CAPTURE_DR:       nxt_state = tms_in ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR:         nxt_state = tms_in ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR:         nxt_state = tms_in ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR:         nxt_state = tms_in ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR:         nxt_state = tms_in ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR:        nxt_state = tms_in ? SELECT_DR_SCAN : RUN_TEST_IDLE;
			SELECT_IR_SCAN:   nxt_state = tms_in ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR:       nxt_state = tms_in ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR:         nxt_state = tms_in ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR:         nxt_state = tms_in ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR:         nxt_state = tms_in ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR:         nxt_state = tms_in ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR:        nxt_state = tms_in ? SELECT_DR_SCAN : RUN_TEST_IDLE;
			default:          nxt_state = TEST_LOGIC_RESET;
		endcase
	end

	// Asynchronous clear so power-up lands in reset without test clock edges
	always_ff @(posedge tck_in or negedge tap_rst_n_in)
	begin
		if (!tap_rst_n_in)
			state_ff <= TEST_LOGIC_RESET;
		else
			state_ff <= nxt_state;
	end

	assign state_out = state_ff;

	chk_fsm_tlr_hold: assert property (@(posedge tck_in) disable iff (!tap_rst_n_in)
		(state_ff == TEST_LOGIC_RESET && tms_in) |=> state_ff == TEST_LOGIC_RESET)
		else $error("reset state left while mode select high");
	chk_fsm_exit1_ir: assert property (@(posedge tck_in) disable iff (!tap_rst_n_in)
		(state_ff == EXIT1_IR) |=> (state_ff == ($past(tms_in) ? UPDATE_IR : PAUSE_IR)))
		else $error("wrong step out of exit1 instruction");
	chk_fsm_update_dr: assert property (@(posedge tck_in) disable iff (!tap_rst_n_in)
		(state_ff == UPDATE_DR && !tms_in) |=> state_ff == RUN_TEST_IDLE)
		else $error("update data did not return to idle");
endmodule : jtag_tap_fsm

// ==== jtag_tap_pkg.sv ====
// Types shared by the test access port controller files
package jtag_tap_pkg;
	typedef enum logic [3:0]
	{
		TEST_LOGIC_RESET,
		RUN_TEST_IDLE,
		SELECT_DR_SCAN,
		CAPTURE_DR,
		SHIFT_DR,
		EXIT1_DR,
		PAUSE_DR,
		EXIT2_DR,
		UPDATE_DR,
		SELECT_IR_SCAN,
		CAPTURE_IR,
		SHIFT_IR,
		EXIT1_IR,
		PAUSE_IR,
		EXIT2_IR,
		UPDATE_IR
	} tap_state_t;
endpackage : jtag_tap_pkg

// ==== jtag_tap_state_controller.sv ====
// Boundary scan port: instruction, data registers, serial output, crossings
`include "jtag_tap_defs.svh"

module jtag_tap_state_controller
	import jtag_tap_pkg::*;
#(
	parameter int BSR_LEN = `TAP_BSR_LEN
)
(
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	input  wire logic               tck_in,
	input  wire logic               tms_in,
	input  wire logic               tdi_in,
	input  wire logic [BSR_LEN-1:0] sys_pins_in,
	output logic                    tdo_out,
	output logic                    tdo_oe_out,
	output logic [BSR_LEN-1:0]      bsr_par_out,
	output logic                    scan_drives_pins_out
);
	localparam int IRW = `TAP_IR_WIDTH;
	localparam int IDW = `TAP_ID_WIDTH;

	tap_state_t             state_w;
	logic                   trst_meta_ff;
	logic                   trst_ff;
	logic [BSR_LEN-1:0]     pins_meta_ff;
	logic [BSR_LEN-1:0]     pins_sync_ff;
	logic [IRW-1:0]         ir_shift_ff;
	logic [IRW-1:0]         ir_ff;
	logic [BSR_LEN-1:0]     bsr_shift_ff;
	logic [BSR_LEN-1:0]     bsr_latch_ff;
	logic [IDW-1:0]         id_shift_ff;
	logic                   bypass_ff;
	logic                   upd_tgl_ff;
	logic                   extest_lvl_ff;
	logic                   tgl_meta_ff;
	logic                   tgl_sync_ff;
	logic                   tgl_seen_ff;
	logic                   ext_meta_ff;
	logic                   dr_serial_bit;

	function automatic logic bsr_selected(input logic [IRW-1:0] ir);
		bsr_selected = (ir == `TAP_IR_EXTEST) || (ir == `TAP_IR_SAMPLE);
	endfunction : bsr_selected

	function automatic logic in_shift(input tap_state_t st);
		in_shift = (st == SHIFT_DR) || (st == SHIFT_IR);
	endfunction : in_shift

	// Test clock domain reset: asserted at once, released on the second test clock edge
	always_ff @(posedge tck_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			trst_meta_ff <= 1'b0;
			trst_ff      <= 1'b0;
		end
		else
		begin
			trst_meta_ff <= 1'b1;
			trst_ff      <= trst_meta_ff;
		end
	end

	jtag_tap_fsm u_fsm
	(
		.tck_in       (tck_in),
		.tap_rst_n_in (trst_ff),
		.tms_in       (tms_in),
		.state_out    (state_w)
	);

	// Device pins are asynchronous to the test clock
	always_ff @(posedge tck_in)
	begin
		pins_meta_ff <= sys_pins_in;
		pins_sync_ff <= pins_meta_ff;
	end

	// Instruction shift path
	always_ff @(posedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
			ir_shift_ff <= `TAP_IR_CAPTURE;
		else
		begin
			case (state_w)
				CAPTURE_IR: ir_shift_ff <= `TAP_IR_CAPTURE;
				SHIFT_IR:   ir_shift_ff <= {tdi_in, ir_shift_ff[IRW-1:1]};
				default:    ir_shift_ff <= ir_shift_ff;
			endcase
		end
	end

	// Current instruction changes on the falling edge so the shift path has settled
	always_ff @(negedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
		begin
			ir_ff         <= `TAP_IR_IDCODE;
			extest_lvl_ff <= 1'b0;
		end
		else if (state_w == TEST_LOGIC_RESET)
		begin
			ir_ff         <= `TAP_IR_IDCODE;
			extest_lvl_ff <= 1'b0;
		end
		else if (state_w == UPDATE_IR)
		begin
			ir_ff         <= ir_shift_ff;
			extest_lvl_ff <= (ir_shift_ff == `TAP_IR_EXTEST);
		end
	end

	// Boundary scan shift path
	always_ff @(posedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
			bsr_shift_ff <= '0;
		else if (bsr_selected(ir_ff))
		begin
			case (state_w)
				CAPTURE_DR: bsr_shift_ff <= pins_sync_ff;
				SHIFT_DR:   bsr_shift_ff <= {tdi_in, bsr_shift_ff[BSR_LEN-1:1]};
				default:    bsr_shift_ff <= bsr_shift_ff;
			endcase
		end
	end

	// Identification register: captures its fixed value, then shifts
	always_ff @(posedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
			id_shift_ff <= `TAP_IDCODE_VALUE;
		else if (ir_ff == `TAP_IR_IDCODE)
		begin
			case (state_w)
				CAPTURE_DR: id_shift_ff <= `TAP_IDCODE_VALUE;
				SHIFT_DR:   id_shift_ff <= {tdi_in, id_shift_ff[IDW-1:1]};
				default:    id_shift_ff <= id_shift_ff;
			endcase
		end
	end

	// One-stage bypass for every other instruction code
	always_ff @(posedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
			bypass_ff <= 1'b0;
		else if (!bsr_selected(ir_ff) && ir_ff != `TAP_IR_IDCODE)
		begin
			case (state_w)
				CAPTURE_DR: bypass_ff <= 1'b0;
				SHIFT_DR:   bypass_ff <= tdi_in;
				default:    bypass_ff <= bypass_ff;
			endcase
		end
	end

	// Latched parallel output only moves in update-data, so shifting never glitches pins
	always_ff @(negedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
		begin
			bsr_latch_ff <= '0;
			upd_tgl_ff   <= 1'b0;
		end
		else if (state_w == UPDATE_DR && bsr_selected(ir_ff))
		begin
			bsr_latch_ff <= bsr_shift_ff;
			upd_tgl_ff   <= ~upd_tgl_ff;
		end
	end

	always_comb
	begin
		if (bsr_selected(ir_ff))
			dr_serial_bit = bsr_shift_ff[0];
		else if (ir_ff == `TAP_IR_IDCODE)
			dr_serial_bit = id_shift_ff[0];
		else
			dr_serial_bit = bypass_ff;
	end

	// Serial output launched on the falling edge for half a cycle of hold at the tester
	always_ff @(negedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
		begin
			tdo_out    <= 1'b0;
			tdo_oe_out <= 1'b0;
		end
		else
		begin
			tdo_oe_out <= in_shift(state_w);
			if (state_w == SHIFT_IR)
				tdo_out <= ir_shift_ff[0];
			else if (state_w == SHIFT_DR)
				tdo_out <= dr_serial_bit;
			else
				tdo_out <= 1'b0;
		end
	end

	// Parallel word crosses by toggle; it stays still for many test clocks after each update
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			tgl_meta_ff <= 1'b0;
			tgl_sync_ff <= 1'b0;
			tgl_seen_ff <= 1'b0;
			bsr_par_out <= '0;
		end
		else
		begin
			tgl_meta_ff <= upd_tgl_ff;
			tgl_sync_ff <= tgl_meta_ff;
			tgl_seen_ff <= tgl_sync_ff;
			if (tgl_sync_ff != tgl_seen_ff)
				bsr_par_out <= bsr_latch_ff;
		end
	end

	// Pins follow the scan path only under external test
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			ext_meta_ff          <= 1'b0;
			scan_drives_pins_out <= 1'b0;
		end
		else
		begin
			ext_meta_ff          <= extest_lvl_ff;
			scan_drives_pins_out <= ext_meta_ff;
		end
	end

	// Helper: consecutive rising edges with mode select high
	logic [2:0] tms_run_ff;
	always_ff @(posedge tck_in or negedge trst_ff)
	begin
		if (!trst_ff)
			tms_run_ff <= 3'h0;
		else if (!tms_in)
			tms_run_ff <= 3'h0;
		else if (tms_run_ff != 3'h5)
			tms_run_ff <= tms_run_ff + 3'h1;
	end

	chk_five_ones_reset: assert property (@(posedge tck_in) disable iff (!trst_ff)
		tms_run_ff == 3'h5 |-> state_w == TEST_LOGIC_RESET)
		else $error("five high mode select edges did not reach reset");

	chk_five_ones_seq: assert property (@(posedge tck_in) disable iff (!trst_ff)
		tms_in [*5] |=> state_w == TEST_LOGIC_RESET)
		else $error("reset state missed after five high edges");

	chk_reset_idcode: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == TEST_LOGIC_RESET |=> ir_ff == `TAP_IR_IDCODE && !extest_lvl_ff)
		else $error("instruction not identify after reset state");

	chk_idle_holds: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == RUN_TEST_IDLE && !tms_in) |=> state_w == RUN_TEST_IDLE
		&& $stable(ir_ff) && $stable(bsr_shift_ff))
		else $error("idle did not hold");

	chk_select_dr_step: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == SELECT_DR_SCAN |=> (state_w == ($past(tms_in) ? SELECT_IR_SCAN : CAPTURE_DR)))
		else $error("wrong step from select data");

	chk_bsr_capture: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == CAPTURE_DR && bsr_selected(ir_ff)) |=> bsr_shift_ff == $past(pins_sync_ff))
		else $error("boundary register did not capture pins");

	chk_bsr_shift: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == SHIFT_DR && bsr_selected(ir_ff)) |=>
		bsr_shift_ff[BSR_LEN-2:0] == $past(bsr_shift_ff[BSR_LEN-1:1])
		&& bsr_shift_ff[BSR_LEN-1] == $past(tdi_in))
		else $error("boundary register did not shift one stage");

	chk_pause_dr_hold: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == PAUSE_DR |=> $stable(bsr_shift_ff) && $stable(id_shift_ff))
		else $error("data register moved during pause");

	chk_latch_only_update: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w != UPDATE_DR |-> $stable(bsr_latch_ff))
		else $error("parallel output changed outside update data");

	chk_latch_takes_shift: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == UPDATE_DR && bsr_selected(ir_ff)) |=> bsr_latch_ff == $past(bsr_shift_ff))
		else $error("parallel output did not take shift path");

	chk_ir_capture_pat: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == CAPTURE_IR |=> ir_shift_ff == `TAP_IR_CAPTURE)
		else $error("instruction capture pattern wrong");

	chk_ir_shift_step: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == SHIFT_IR |=> ir_shift_ff == {$past(tdi_in), $past(ir_shift_ff[IRW-1:1])})
		else $error("instruction register did not shift");

	chk_ir_update_load: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == UPDATE_IR |=> ir_ff == $past(ir_shift_ff))
		else $error("instruction not latched in update");

	chk_ir_stable_scan: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w inside {EXIT1_IR, PAUSE_IR, EXIT2_IR, SHIFT_IR}) |-> $stable(ir_ff))
		else $error("instruction changed during instruction scan");

	chk_tdo_off_idle: assert property (@(posedge tck_in) disable iff (!trst_ff)
		!in_shift(state_w) |-> !tdo_oe_out)
		else $error("serial output enabled outside shift");

	chk_tdo_ir_bit: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == SHIFT_IR |-> tdo_oe_out && tdo_out == ir_shift_ff[0])
		else $error("serial output not instruction stage zero");

	// Falling-edge launch means the bit seen at a rising edge belongs to the ending cycle
	chk_tdo_bsr_bit: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == SHIFT_DR && bsr_selected(ir_ff)) |-> tdo_oe_out && tdo_out == bsr_shift_ff[0])
		else $error("serial output not boundary stage zero");

	chk_capture_dr_step: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == CAPTURE_DR |=> (state_w == ($past(tms_in) ? EXIT1_DR : SHIFT_DR)))
		else $error("wrong step from capture data");

	chk_idle_leaves: assert property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == RUN_TEST_IDLE && tms_in) |=> state_w == SELECT_DR_SCAN)
		else $error("idle did not go to select data");

	chk_exit2_dr_step: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == EXIT2_DR |=> (state_w == ($past(tms_in) ? UPDATE_DR : SHIFT_DR)))
		else $error("wrong step from exit2 data");

	chk_select_ir_step: assert property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == SELECT_IR_SCAN |=>
		(state_w == ($past(tms_in) ? TEST_LOGIC_RESET : CAPTURE_IR)))
		else $error("wrong step from select instruction");

	cov_ir_scan: cover property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == SHIFT_IR ##1 state_w == EXIT1_IR ##1 state_w == UPDATE_IR);
	cov_dr_pause: cover property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == PAUSE_DR ##1 state_w == EXIT2_DR ##1 state_w == SHIFT_DR);
	cov_extest_update: cover property (@(posedge tck_in) disable iff (!trst_ff)
		state_w == UPDATE_DR && ir_ff == `TAP_IR_EXTEST);
	cov_five_reset: cover property (@(posedge tck_in) disable iff (!trst_ff)
		(state_w == SHIFT_DR && tms_in) ##1 tms_in [*4] ##1 state_w == TEST_LOGIC_RESET);
endmodule : jtag_tap_state_controller

// ==== jtag_tap_state_controller_tb.sv ====
// Self-checking bench for the test access port controller
`include "jtag_tap_defs.svh"

module jtag_tap_state_controller_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk_in;
	logic        rst_n_in;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe;
	logic        drives;
	logic [15:0] pins;
	logic [15:0] par;
	logic [31:0] q;
	logic [31:0] r;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	jtag_tap_state_controller #(.BSR_LEN(16)) uut
	(
		.clk_in               (clk_in),
		.rst_n_in             (rst_n_in),
		.tck_in               (tck),
		.tms_in               (tms),
		.tdi_in               (tdi),
		.sys_pins_in          (pins),
		.tdo_out              (tdo),
		.tdo_oe_out           (tdo_oe),
		.bsr_par_out          (par),
		.scan_drives_pins_out (drives)
	);

	jtag_tap_tester tester
	(
		.tck_out   (tck),
		.tms_out   (tms),
		.tdi_out   (tdi),
		.tdo_in    (tdo),
		.tdo_oe_in (tdo_oe)
	);

	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want)
		begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// Hang guard: the whole run needs far fewer cycles
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles >= 20000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic clks(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : clks

	// Reset with no test clock, then five effective high edges past the release
	task automatic do_reset();
		clks(1);
		rst_n_in = 1'b0;
		clks(5);
		check(tdo_oe, 1'b0);
		check(drives, 1'b0);
		check(par, 16'h0);
		rst_n_in = 1'b1;
		clks(1);
		tester.moves(8'h7f, 7);
		tester.moves(8'h00, 1);
	endtask : do_reset

	task automatic t_idcode();
		tester.scan_dr(32'h0, 32, q);
		check(q, `TAP_IDCODE_VALUE);
		check(tdo_oe, 1'b0);
	endtask : t_idcode

	// Bypass gives one stage of delay and must not touch the parallel output
	task automatic t_bypass();
		tester.scan_ir(`TAP_IR_BYPASS, q);
		check(q, `TAP_IR_CAPTURE);
		tester.scan_dr(32'h0b5, 9, q);
		clks(6);
		check(q, 32'h16a);
		check(par, 16'h0);
	endtask : t_bypass

	task automatic t_boundary(input logic [2:0] code, input logic [15:0] p, input logic [15:0] d);
		tester.scan_ir(code, q);
		clks(1);
		pins = p;
		clks(3);
		check(drives, code == `TAP_IR_EXTEST);
		tester.scan_dr({16'h0, d}, 16, q);
		check(q, {16'h0, p});
		clks(6);
		check(par, d);
	endtask : t_boundary

	// Instruction and data scans both broken by pauses mid-stream
	task automatic t_pause();
		tester.scan_ir(`TAP_IR_BYPASS, q);
		tester.moves(8'h03, 4);
		tester.shift(32'h0, 1, q);
		tester.moves(8'h04, 4);
		check(tdo_oe, 1'b1);
		tester.shift(32'h1, 2, r);
		tester.moves(8'h01, 2);
		check({r[1:0], q[0]}, `TAP_IR_CAPTURE);
		tester.moves(8'h01, 3);
		tester.shift(32'h0, 16, q);
		tester.moves(8'h04, 4);
		tester.shift(32'h0, 16, r);
		tester.moves(8'h01, 2);
		check({r[15:0], q[15:0]}, `TAP_IDCODE_VALUE);
	endtask : t_pause

	// Five high edges from mid-shift pass through the instruction select branch
	task automatic t_escape();
		tester.scan_ir(`TAP_IR_BYPASS, q);
		tester.moves(8'h01, 3);
		tester.moves(8'h1f, 5);
		tester.moves(8'h00, 1);
		t_idcode();
	endtask : t_escape

	initial
	begin
		rst_n_in = 1'b0;
		pins = 16'h0;
		do_reset();
		t_idcode();
		t_bypass();
		t_boundary(`TAP_IR_SAMPLE, 16'ha5c3, 16'h3c96);
		t_boundary(`TAP_IR_EXTEST, 16'h0ff0, 16'h1234);
		t_pause();
		t_escape();
		t_boundary(`TAP_IR_EXTEST, 16'h8001, 16'h7ffe);
		do_reset();
		t_idcode();
		complete_run();
	end
endmodule : jtag_tap_state_controller_tb

// ==== jtag_tap_tester.sv ====
// Behavioural board tester that drives the serial test port
module jtag_tap_tester
(
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_in
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b0;
	end

	// One 12 ns cycle; the clock stands low between calls, as a real tester leaves it
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_out = tms;
		tdi_out = tdi;
		#5 tck_out = 1'b1;
		tdo = tdo_oe_in ? tdo_in : 1'bx;
		#6 tck_out = 1'b0;
		#1;
	endtask : step

	// Walks the state graph; data line toggles so stale levels are never trusted
	task automatic moves(input logic [7:0] seq, input int n);
		logic t;
		for (int i = 0; i < n; i++)
			step(seq[i], ~tdi_out, t);
	endtask : moves

	// Lowest bit first; mode select rises with the last bit
	task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
	endtask : shift

	task automatic scan_dr(input logic [31:0] din, input int n, output logic [31:0] dout);
		moves(8'h01, 3);
		shift(din, n, dout);
		moves(8'h01, 2);
	endtask : scan_dr

	task automatic scan_ir(input logic [2:0] code, output logic [31:0] dout);
		moves(8'h03, 4);
		shift({29'h0, code}, 3, dout);
		moves(8'h01, 2);
	endtask : scan_ir
endmodule : jtag_tap_tester
